// [hpm_pin_mux.sv]
// hub pin function mux for spi, over-current, uart and clock pins
`timescale 1ns/1ps

module hpm_pin_mux (
    input  wire logic             i_clk_sys,
    input  wire logic             i_resetn,
    // configuration and state
    input  wire logic             i_spi_master_dis,
    input  wire logic             i_spi_dis,
    input  wire logic             i_powerdown,
    input  wire logic             i_suspend,
    input  wire logic             i_uart_en,
    input  wire logic             i_ocs1_gpio_mode,
    input  wire logic             i_ocs2_gpio_mode,
    input  wire logic             i_use_oscillator,
    // spi master core
    input  wire logic             i_spi_sel,
    input  wire logic             i_spi_active,
    input  wire logic             i_spi_mosi,
    output logic                  o_flash_data_in,
    output logic                  o_spi_fast,
    // gpio controller
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_four,
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_five,
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_nine,
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_seventeen,
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_eighteen,
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_nineteen,
    input  wire hpm_pkg::hpm_gpio_t i_gp_io_twenty,
    output logic [6:0]            o_gp_io_in,
    // uart core
    input  wire logic             i_uart_txd,
    output logic                  o_uart_rxd,
    // over-current status, active high
    output logic                  o_port1_overcurrent,
    output logic                  o_port2_overcurrent,
    // pad side
    input  wire logic             i_pad_ce,
    input  wire logic             i_pad_clk,
    input  wire logic             i_pad_do,
    input  wire logic             i_pad_di,
    input  wire logic             i_port1_overcurrent_low,
    input  wire logic             i_port2_overcurrent_low,
    input  wire logic             i_pad_rx,
    input  wire logic             i_pad_tx,
    input  wire logic             i_crystal_in,
    output hpm_pkg::hpm_pin_t     o_pad_ce,
    output hpm_pkg::hpm_pin_t     o_pad_clk,
    output hpm_pkg::hpm_pin_t     o_pad_do,
    output hpm_pkg::hpm_pin_t     o_pad_di,
    output hpm_pkg::hpm_pin_t     o_pad_oc1,
    output hpm_pkg::hpm_pin_t     o_pad_oc2,
    output hpm_pkg::hpm_pin_t     o_pad_rx,
    output hpm_pkg::hpm_pin_t     o_pad_tx,
    output logic                  o_crystal_out_en,
    output logic                  o_ref_clk
);

    // idle pad states shared by the pad registers
    localparam hpm_pkg::hpm_pin_t PAD_RELEASED = '{o: hpm_pkg::PIN_LOW, oe: 1'h0};
    localparam hpm_pkg::hpm_pin_t TX_RELEASED  = '{o: hpm_pkg::PIN_HIGH, oe: 1'h0};
    localparam hpm_pkg::hpm_pin_t CE_DESELECT  = '{o: hpm_pkg::CE_IDLE, oe: 1'h1};

    hpm_pkg::hpm_pin_t tx_func;
    logic       strap_r;
    logic       strap_done_r;
    logic [3:0] div_cnt_r;
    logic       spi_clk_r;
    logic [3:0] half_nxt;
    logic       ref_meta_r;
    logic       ref_sync_r;

    // strap captured once after reset release, never resampled
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            strap_done_r <= 1'b0;
            strap_r      <= hpm_pkg::SPD_STRAP_30;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_r      <= i_pad_do;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_spi_fast <= 1'b0;
        end else begin
            o_spi_fast <= (strap_r == hpm_pkg::SPD_STRAP_60);
        end
    end

    // spi clock divider: half period chosen by strap
    always_comb begin
        half_nxt = (strap_r == hpm_pkg::SPD_STRAP_60) ? hpm_pkg::SPI_HALF_FAST
                                                       : hpm_pkg::SPI_HALF_SLOW;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !i_spi_active) begin
            div_cnt_r <= 4'h0;
            spi_clk_r <= hpm_pkg::PIN_LOW;
        end else if (div_cnt_r + 4'h1 >= half_nxt) begin
            div_cnt_r <= 4'h0;
            spi_clk_r <= ~spi_clk_r;
        end else begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    // flash chip enable: deselected whenever the flash must stay quiet
    // powerdown wins over a select request so the flash never wakes half powered
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_pad_ce <= CE_DESELECT;
        end else if (i_spi_master_dis) begin
            o_pad_ce <= CE_DESELECT;
        end else if (i_powerdown) begin
            o_pad_ce <= CE_DESELECT;
        end else if (i_spi_sel) begin
            o_pad_ce <= '{o: hpm_pkg::CE_ACT, oe: 1'h1};
        end else begin
            o_pad_ce <= CE_DESELECT;
        end
    end

    // spi clock pin or gpio four
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_pad_clk <= PAD_RELEASED;
        end else if (i_spi_master_dis) begin
            o_pad_clk <= i_gp_io_four;
        end else begin
            o_pad_clk <= '{o: spi_clk_r, oe: 1'h1};
        end
    end

    // spi data out pin or gpio five; released in reset so the strap can be read
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_pad_do <= PAD_RELEASED;
        end else if (i_spi_master_dis) begin
            o_pad_do <= i_gp_io_five;
        end else if (i_suspend && strap_r == hpm_pkg::SPD_STRAP_60) begin
            o_pad_do <= PAD_RELEASED;
        end else if (i_suspend) begin
            o_pad_do <= '{o: hpm_pkg::PIN_LOW, oe: 1'h1};
        end else begin
            o_pad_do <= '{o: i_spi_mosi, oe: 1'h1};
        end
    end

    // data input pin: gpio nine when spi is off, otherwise input only
    hpm_pad_reg u_pad_di (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_gpio_sel(i_spi_dis),
        .i_func    (PAD_RELEASED),
        .i_gpio    (i_gp_io_nine),
        .i_rst_val (PAD_RELEASED),
        .o_pad     (o_pad_di)
    );

    // flash data reads zero while its pin serves as gpio
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_flash_data_in <= hpm_pkg::PIN_LOW;
        end else if (i_spi_dis) begin
            o_flash_data_in <= hpm_pkg::PIN_LOW;
        end else begin
            o_flash_data_in <= i_pad_di;
        end
    end

    // over-current sense, active low from the current monitors
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_port1_overcurrent <= 1'h0;
            o_port2_overcurrent <= 1'h0;
        end else begin
            o_port1_overcurrent <= !i_ocs1_gpio_mode && !i_port1_overcurrent_low;
            o_port2_overcurrent <= !i_ocs2_gpio_mode && !i_port2_overcurrent_low;
        end
    end

    // over-current pins fall back to gpio 17 and 18; in sense mode they are inputs only
    hpm_pad_reg u_pad_oc1 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_gpio_sel(i_ocs1_gpio_mode),
        .i_func    (PAD_RELEASED),
        .i_gpio    (i_gp_io_seventeen),
        .i_rst_val (PAD_RELEASED),
        .o_pad     (o_pad_oc1)
    );

    hpm_pad_reg u_pad_oc2 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_gpio_sel(i_ocs2_gpio_mode),
        .i_func    (PAD_RELEASED),
        .i_gpio    (i_gp_io_eighteen),
        .i_rst_val (PAD_RELEASED),
        .o_pad     (o_pad_oc2)
    );

    // uart receive reads idle high while the pins serve as gpio
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_uart_rxd <= hpm_pkg::PIN_HIGH;
        end else if (i_uart_en) begin
            o_uart_rxd <= i_pad_rx;
        end else begin
            o_uart_rxd <= hpm_pkg::PIN_HIGH;
        end
    end

    assign tx_func = '{o: i_uart_txd, oe: 1'h1};

    // uart pins or gpio 19 and 20
    hpm_pad_reg u_pad_rx (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_gpio_sel(!i_uart_en),
        .i_func    (PAD_RELEASED),
        .i_gpio    (i_gp_io_nineteen),
        .i_rst_val (PAD_RELEASED),
        .o_pad     (o_pad_rx)
    );

    // tx idles high in reset so the far receiver sees no false start bit
    hpm_pad_reg u_pad_tx (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_gpio_sel(!i_uart_en),
        .i_func    (tx_func),
        .i_gpio    (i_gp_io_twenty),
        .i_rst_val (TX_RELEASED),
        .o_pad     (o_pad_tx)
    );

    // pad input readback for the gpio controller
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_gp_io_in <= 7'h00;
        end else begin
            o_gp_io_in <= {i_pad_tx, i_pad_rx, i_port2_overcurrent_low,
                           i_port1_overcurrent_low, i_pad_di, i_pad_do, i_pad_clk};
        end
    end

    // reference clock: crystal driver disabled when an oscillator feeds the input
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ref_meta_r       <= 1'b0;
            ref_sync_r       <= 1'b0;
            o_ref_clk        <= 1'b0;
            o_crystal_out_en <= 1'b1;
        end else begin
            ref_meta_r       <= i_crystal_in;
            ref_sync_r       <= ref_meta_r;
            o_ref_clk        <= ref_sync_r;
            o_crystal_out_en <= !i_use_oscillator;
        end
    end

endmodule : hpm_pin_mux

// registered pad driver: function value or gpio request, idle value in reset
module hpm_pad_reg (
    input  wire logic               i_clk_sys,
    input  wire logic               i_resetn,
    input  wire logic               i_gpio_sel,
    input  wire hpm_pkg::hpm_pin_t  i_func,
    input  wire hpm_pkg::hpm_gpio_t i_gpio,
    input  wire hpm_pkg::hpm_pin_t  i_rst_val,
    output hpm_pkg::hpm_pin_t       o_pad
);

    // reset value is a port so each pad keeps its own idle level
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_pad <= i_rst_val;
        end else if (i_gpio_sel) begin
            o_pad <= i_gpio;
        end else begin
            o_pad <= i_func;
        end
    end

endmodule : hpm_pad_reg

// [hpm_pkg.sv]
// package for the hub pin function mux: constants and carrier structs
package hpm_pkg;

    // spi speed select strap encodings
    localparam logic       SPD_STRAP_30 = 1'b0;
    localparam logic       SPD_STRAP_60 = 1'b1;

    // spi master bit rates in mhz
    localparam int         SPI_MHZ_SLOW = 30;
    localparam int         SPI_MHZ_FAST = 60;

    // system clock and external reset pulse width
    localparam int         SYS_CLK_MHZ      = 125;
    localparam int         RESET_MIN_NS     = 5000;
    localparam int         RESET_MIN_CYCLES = (RESET_MIN_NS * SYS_CLK_MHZ + 999) / 1000;

    // reference clock frequency
    localparam int         REF_CLK_MHZ = 24;

    // spi clock divider half periods at the system clock; the rates are the nearest reachable
    localparam logic [3:0] SPI_HALF_SLOW = 4'h2;
    localparam logic [3:0] SPI_HALF_FAST = 4'h1;

    // pin reset and active levels
    localparam logic       CE_IDLE  = 1'b1;
    localparam logic       CE_ACT   = 1'b0;
    localparam logic       PIN_LOW  = 1'b0;
    localparam logic       PIN_HIGH = 1'b1;

    // one tri-state pin: out value and output enable
    typedef struct packed {
        logic o;
        logic oe;
    } hpm_pin_t;

    // general purpose drive request from the gpio controller
    typedef struct packed {
        logic o;
        logic oe;
    } hpm_gpio_t;

endpackage : hpm_pkg

// [hpm_pin_mux_sva.sv]
// port assertions for the hub pin mux
`timescale 1ns/1ps
module hpm_pin_mux_sva (
    input wire logic              i_clk_sys,
    input wire logic              i_resetn,
    input wire logic              i_spi_master_dis,
    input wire logic              i_powerdown,
    input wire logic              i_suspend,
    input wire logic              i_spi_sel,
    input wire logic              i_ocs1_gpio_mode,
    input wire logic              i_ocs2_gpio_mode,
    input wire logic              i_port1_overcurrent_low,
    input wire logic              i_port2_overcurrent_low,
    input wire logic              o_spi_fast,
    input wire logic              o_port1_overcurrent,
    input wire logic              o_port2_overcurrent,
    input wire hpm_pkg::hpm_pin_t o_pad_ce,
    input wire hpm_pkg::hpm_pin_t o_pad_do
);
    wire spi_on = !i_spi_master_dis;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    ce_pd_hi_a: assert property (spi_on && i_powerdown |=> o_pad_ce == 2'h3)
        else $error("ce not high in powerdown");
    ce_sel_lo_a: assert property (spi_on && !i_powerdown && i_spi_sel |=> o_pad_ce == 2'h1)
        else $error("ce not low when selected");
    // strap may settle two edges after release, then never moves
    strap_hold_a: assert property ($past(i_resetn, 3) |-> $stable(o_spi_fast))
        else $error("speed strap moved");
    susp_float_a: assert property (spi_on && i_suspend && o_spi_fast |=> !o_pad_do.oe)
        else $error("data out driven in suspend");
    susp_low_a: assert property (spi_on && i_suspend && !o_spi_fast |=> o_pad_do == 2'h1)
        else $error("data out not low in suspend");
    oc1_lvl_a: assert property (!i_ocs1_gpio_mode |=>
        o_port1_overcurrent != $past(i_port1_overcurrent_low)) else $error("port 1 status wrong");
    oc2_lvl_a: assert property (!i_ocs2_gpio_mode |=>
        o_port2_overcurrent != $past(i_port2_overcurrent_low)) else $error("port 2 status wrong");
    oc1_gpio_a: assert property (i_ocs1_gpio_mode |=> !o_port1_overcurrent)
        else $error("port 1 status set in gpio mode");
    oc2_gpio_a: assert property (i_ocs2_gpio_mode |=> !o_port2_overcurrent)
        else $error("port 2 status set in gpio mode");
endmodule : hpm_pin_mux_sva

bind hpm_pin_mux hpm_pin_mux_sva u_sva (.*);

// [hpm_flash_model.sv]
// far side model: serial flash data line and two current monitors
`timescale 1ns/1ps
module hpm_flash_model (
    input  wire hpm_pkg::hpm_pin_t i_ce,
    input  wire logic [1:0]        i_fault,
    output logic                   o_di,
    output logic [1:0]             o_oc_low
);
    // erased flash answers ones; a released line falls to its pull-down
    assign o_di = i_ce.oe && i_ce.o == hpm_pkg::CE_ACT;
    assign o_oc_low = ~i_fault;
endmodule : hpm_flash_model

// [tb_top.sv]
// self-checking bench for the hub pin mux
`timescale 1ns/1ps
`define CK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
    logic i_clk_sys, i_resetn, i_spi_master_dis, i_spi_dis, i_powerdown, i_suspend, i_uart_en;
    logic i_ocs1_gpio_mode, i_ocs2_gpio_mode, i_use_oscillator, i_spi_sel, i_spi_active;
    logic i_spi_mosi, i_uart_txd, i_pad_ce, i_pad_clk, i_pad_do, i_pad_rx, i_pad_tx;
    logic i_crystal_in, o_flash_data_in, o_spi_fast, o_uart_rxd, o_crystal_out_en, o_ref_clk;
    logic o_port1_overcurrent, o_port2_overcurrent;
    logic [6:0] o_gp_io_in;
    logic [1:0] fault;
    wire        i_pad_di, i_port1_overcurrent_low, i_port2_overcurrent_low;
    hpm_pkg::hpm_gpio_t i_gp_io_four, i_gp_io_five, i_gp_io_nine, i_gp_io_seventeen;
    hpm_pkg::hpm_gpio_t i_gp_io_eighteen, i_gp_io_nineteen, i_gp_io_twenty;
    hpm_pkg::hpm_pin_t  o_pad_ce, o_pad_clk, o_pad_do, o_pad_di, o_pad_oc1, o_pad_oc2;
    hpm_pkg::hpm_pin_t  o_pad_rx, o_pad_tx;
    int error_cnt = 0;
    int num_checks = 0;
    hpm_pin_mux u_dut (.*);
    hpm_flash_model u_flash (.i_ce(o_pad_ce), .i_fault(fault), .o_di(i_pad_di),
        .o_oc_low({i_port2_overcurrent_low, i_port1_overcurrent_low}));
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick
    task automatic t_boot(input logic strap, input int hold);
        logic [3:0] flips;
        logic       last;
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        i_pad_do <= strap;
        tick(hold);
        `CK("ce rst", 2'h3, o_pad_ce)
        @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        tick(1);
        // late strap change must be ignored
        @(posedge i_clk_sys);
        i_pad_do <= ~strap;
        i_spi_active <= 1'b1;
        tick(4);
        `CK("strap", strap, o_spi_fast)
        flips = 4'h0;
        for (int k = 0; k < 8; k++) begin
            last = o_pad_clk.o;
            tick(1);
            flips = flips + 4'(o_pad_clk.o != last);
        end
        last = strap;
        `CK("clk flips", last ? 4'h8 / hpm_pkg::SPI_HALF_FAST : 4'h8 / hpm_pkg::SPI_HALF_SLOW, flips)
        @(posedge i_clk_sys);
        i_spi_active <= 1'b0;
        i_suspend <= 1'b1;
        i_spi_mosi <= 1'b1;
        tick(1);
        `CK("do oe", ~strap, o_pad_do.oe)
        if (!strap) `CK("do low", 1'b0, o_pad_do.o)
        @(posedge i_clk_sys);
        i_suspend <= 1'b0;
    endtask : t_boot
    task automatic t_ce;
        @(posedge i_clk_sys);
        i_spi_sel <= 1'b1;
        tick(2);
        `CK("ce sel", 3'h3, {o_pad_ce, o_flash_data_in})
        @(posedge i_clk_sys);
        i_spi_dis <= 1'b1;
        i_powerdown <= 1'b1;
        tick(1);
        `CK("ce pd", 2'h3, o_pad_ce)
        `CK("di gpio", {i_gp_io_nine, 1'b0}, {o_pad_di, o_flash_data_in})
        @(posedge i_clk_sys);
        i_spi_master_dis <= 1'b1;
        tick(1);
        `CK("clk do gpio", {i_gp_io_four, i_gp_io_five}, {o_pad_clk, o_pad_do})
        @(posedge i_clk_sys);
        {i_spi_sel, i_spi_dis, i_powerdown, i_spi_master_dis} <= 4'h0;
    endtask : t_ce
    task automatic t_misc;
        @(posedge i_clk_sys);
        fault <= 2'h1;
        i_uart_en <= 1'b1;
        i_use_oscillator <= 1'b1;
        i_crystal_in <= 1'b1;
        tick(1);
        `CK("oc", 2'h1, {o_port2_overcurrent, o_port1_overcurrent})
        `CK("uart", 5'h08, {o_pad_tx, o_pad_rx, o_uart_rxd})
        `CK("xo en", 1'b0, o_crystal_out_en)
        @(posedge i_clk_sys);
        fault <= 2'h2;
        i_ocs1_gpio_mode <= 1'b1;
        i_uart_en <= 1'b0;
        tick(2);
        `CK("ref clk", 1'b1, o_ref_clk)
        `CK("oc gpio", {2'h2, i_gp_io_seventeen, 2'h0}, {o_port2_overcurrent, o_port1_overcurrent, o_pad_oc1, o_pad_oc2})
        `CK("pad readback", 7'h08, o_gp_io_in)
        `CK("uart gpio", {i_gp_io_twenty, i_gp_io_nineteen}, {o_pad_tx, o_pad_rx})
    endtask : t_misc
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {i_resetn, i_spi_master_dis, i_spi_dis, i_powerdown, i_suspend, i_uart_en} = 6'h0;
        {i_ocs1_gpio_mode, i_ocs2_gpio_mode, i_use_oscillator, i_spi_sel, i_spi_active} = 5'h0;
        {i_spi_mosi, i_uart_txd, i_pad_ce, i_pad_clk, i_pad_do, i_pad_rx, i_pad_tx} = 7'h0;
        {i_crystal_in, fault} = 3'h0;
        {i_gp_io_four, i_gp_io_five, i_gp_io_nine, i_gp_io_seventeen} = 8'haf;
        {i_gp_io_eighteen, i_gp_io_nineteen, i_gp_io_twenty} = 6'h2e;
        t_boot(1'b1, 3);
        t_ce;
        t_misc;
        t_boot(1'b0, hpm_pkg::RESET_MIN_CYCLES);
        report_and_stop;
    end
endmodule : tb_top
